// >>> pd_map_pkg.sv
// Constants and types shared by the process word mapper and its FIFO.
// Assumes a single 250 MHz clock domain and synchronous active-low reset.
`default_nettype none

package pd_map_pkg;

    // ==================================================================
    // Identifier arithmetic
    // ==================================================================
    localparam int unsigned ADDR_SHIFT     = 3;        // Eight ids per address
    localparam logic [2:0]  FIX_IN_OFS     = 3'h0;     // Three-word drive, inputs
    localparam logic [2:0]  FIX_OUT_OFS    = 3'h1;     // Three-word drive, outputs
    // Multi-axis offsets, indexed by telegram number
    localparam logic [3:0][2:0] MA_IN_OFS  = {3'h7, 3'h5, 3'h4, 3'h3};
    localparam logic [3:0][2:0] MA_OUT_OFS = {3'h6, 3'h2, 3'h1, 3'h0};
    localparam logic [10:0] SYNC_ID        = 11'h001;  // Sync on both channels

    // ==================================================================
    // Sizes and fixed values
    // ==================================================================
    localparam int unsigned WORDS_PER_TEL  = 4;        // Words in one telegram
    localparam int unsigned MAX_TELS       = 4;        // Telegrams per direction
    localparam logic [4:0]  FIXED_WORDS    = 5'h03;    // Three-word drive size
    localparam logic [4:0]  MA_WORDS_MAX   = 5'h10;    // Multi-axis upper bound
    localparam logic [6:0]  PWC_MIN        = 7'h01;    // Process word count min
    localparam logic [6:0]  PWC_MAX        = 7'h40;    // Process word count max
    localparam logic [15:0] FAULT_TIMEOUT  = 16'h006f; // Fault 111 code
    localparam logic [15:0] WORD_RST       = 16'h0000; // Image value after reset
    localparam int unsigned FIFO_DEPTH     = 16;       // Output word buffer

    // ==================================================================
    // Types
    // ==================================================================
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COLLECT,
        ST_SEND,
        ST_SYNC
    } map_state_t;

endpackage

`default_nettype wire

// >>> pd_word_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth must be a power of two.
`default_nettype none

module pd_word_fifo
    import pd_map_pkg::*;
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_b_i,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Drain side
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage
        logic [AW:0]                 wr;    // Write pointer, wrap bit on top
        logic [AW:0]                 rd;    // Read pointer, wrap bit on top
    } fifo_state_t;

    fifo_state_t s_reg;                     // Registered state
    fifo_state_t s_next;                    // Next state
    logic        full;                      // No room left
    logic        empty;                     // Nothing stored

    // Wrap bits differ with equal index when full
    assign full        = (s_reg.wr[AW] != s_reg.rd[AW]) && (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]);
    assign empty       = (s_reg.wr == s_reg.rd);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = s_reg.mem[s_reg.rd[AW-1:0]];

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        s_next = s_reg;
        // Push while room remains
        if (in_valid_i && !full) begin
            s_next.mem[s_reg.wr[AW-1:0]] = in_data_i;
            s_next.wr                    = s_reg.wr + 1'b1;
        end
        // Pop while data remains
        if (out_ready_i && !empty) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
    end

    // Register; storage need not be cleared
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            s_reg.wr  <= '0;
            s_reg.rd  <= '0;
            s_reg.mem <= s_next.mem;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

`default_nettype wire

// >>> pd_can_id_mapper.sv
// Maps one drive's process words to system_bus telegrams and back.
// Assumes fieldbus words arrive in ascending order, one drive per instance,
// and that the telegram sender takes tx only when tx_ready_i is high.
//
// What this block does
// [RQ1] Three-word drive: one telegram, ids 8a, 8a+1
// [RQ2] Multi-axis up to four: ids 8a+3, 8a+0
// [RQ3] Telegram count is words divided by four, rounded up
// [RQ4] Second telegram ids 8a+4 and 8a+1
// [RQ5] Third telegram ids 8a+5 and 8a+2
// [RQ6] Fourth telegram ids 8a+7 and 8a+6
// [RQ7] Sync telegram id 1 on both channels
// [RQ8] Word count 1..64, sixteen-bit words each
// [RQ9] Master sets polled lengths to twice count
// [RQ10] Master node address equals switch address
// [RQ11] Fieldbus lost: send zeros, resume automatically
// [RQ12] Slave timeout: fault 111 in word zero
// [RQ13] At most four words per telegram, ascending order
`default_nettype none

module pd_can_id_mapper
    import pd_map_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    // Configuration
    input  wire logic [ADDR_W-1:0] system_bus_addr_i,
    input  wire logic              multi_axis_i,
    input  wire logic [4:0]        drive_words_i,
    input  wire logic [6:0]        process_word_count_i,
    input  wire logic              fieldbus_ok_i,
    input  wire logic              slave_timeout_i,
    // Fieldbus output words
    input  wire logic [15:0]       output_words_i,
    input  wire logic              output_valid_i,
    output logic                   output_ready_o,
    // Fieldbus input words
    input  wire logic [3:0]        input_index_i,
    output logic [15:0]            input_words_o,
    output logic [7:0]             io_bytes_o,
    // Cycle control
    input  wire logic              cycle_start_i,
    output logic                   busy_o,
    // Telegram transmit
    output logic                   tx_valid_o,
    input  wire logic              tx_ready_i,
    output logic [10:0]            tx_id_o,
    output logic [63:0]            tx_data_o,
    output logic [2:0]             tx_len_o,
    output logic                   tx_both_o,
    // Telegram receive
    input  wire logic              rx_valid_i,
    input  wire logic [10:0]       rx_id_i,
    input  wire logic [63:0]       rx_data_i
);
    localparam int unsigned IDW = ADDR_W + ADDR_SHIFT;

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        map_state_t              st;        // Cycle phase
        logic [2:0]              tel;       // Telegrams sent this cycle
        logic [4:0]              left;      // Words still to send
        logic [2:0]              fill;      // Words gathered for telegram
        logic [3:0][15:0]        buf_w;     // Gathered words
        logic [10:0]             id;        // Identifier being sent
        logic [2:0]              len;       // Words in telegram being sent
        logic                    both;      // Sync goes on both channels
        logic [15:0][15:0]       img;       // Input image from the slave
        logic [15:0]             rd;        // Input word presented
        logic [7:0]              io_bytes;  // Polled length the master needs
    } map_reg_t;

    map_reg_t    s_reg;                     // Registered state
    map_reg_t    s_next;                    // Next state
    logic [15:0] fifo_word;                 // Word at FIFO head
    logic        fifo_valid;                // FIFO holds a word
    logic        fifo_pop;                  // Take head word
    logic [4:0]  words;                     // Words per cycle for this drive
    logic [2:0]  want;                      // Words for current telegram
    logic [2:0]  exp_tels;                  // Telegrams per cycle
    logic [6:0]  pwc;                       // Clamped process word count
    logic [IDW-1:0] base_id;                // Address times eight

    // Output words wait here so the fieldbus side sees back-pressure
    pd_word_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .in_data_i   (output_words_i),
        .in_valid_i  (output_valid_i),
        .in_ready_o  (output_ready_o),
        .out_data_o  (fifo_word),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // ==================================================================
    // Derived sizes
    // ==================================================================
    always_comb begin
        base_id = IDW'(system_bus_addr_i) << ADDR_SHIFT;
        // [RQ3] Count from word total
        if (!multi_axis_i) begin
            words = FIXED_WORDS;
        end else if (drive_words_i == 5'h00) begin
            words = 5'h01;
        end else if (drive_words_i > MA_WORDS_MAX) begin
            words = MA_WORDS_MAX;
        end else begin
            words = drive_words_i;
        end
        exp_tels = 3'((words + 5'h03) >> 2);
        // [RQ13] At most four per telegram
        want = (s_reg.left > 5'h04) ? 3'h4 : s_reg.left[2:0];
        // [RQ8] Keep count within 1..64
        if (process_word_count_i < PWC_MIN) begin
            pwc = PWC_MIN;
        end else if (process_word_count_i > PWC_MAX) begin
            pwc = PWC_MAX;
        end else begin
            pwc = process_word_count_i;
        end
    end

    // Output identifier for a telegram number
    function automatic logic [10:0] out_id(input logic [1:0] n);
        logic [IDW-1:0] v;
        v = multi_axis_i ? (base_id | IDW'(MA_OUT_OFS[n])) : (base_id | IDW'(FIX_OUT_OFS));
        return 11'(v);
    endfunction

    // Input identifier for a telegram number
    function automatic logic [10:0] in_id(input logic [1:0] n);
        logic [IDW-1:0] v;
        v = multi_axis_i ? (base_id | IDW'(MA_IN_OFS[n])) : (base_id | IDW'(FIX_IN_OFS));
        return 11'(v);
    endfunction

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        s_next   = s_reg;
        fifo_pop = 1'b0;
        // [RQ8] [RQ9] Polled length is twice count
        s_next.io_bytes = {pwc, 1'b0};
        case (s_reg.st)
            // Wait for the cycle trigger
            ST_IDLE: begin
                if (cycle_start_i) begin
                    s_next.st   = ST_COLLECT;
                    s_next.tel  = 3'h0;
                    s_next.left = words;
                    s_next.fill = 3'h0;
                end
            end
            // Gather up to four words
            ST_COLLECT: begin
                if (s_reg.fill < want) begin
                    // [RQ11] Zeros while fieldbus down
                    if (!fieldbus_ok_i) begin
                        s_next.buf_w[s_reg.fill[1:0]] = WORD_RST;
                        s_next.fill                   = s_reg.fill + 3'h1;
                        fifo_pop                      = fifo_valid;
                    end else if (fifo_valid) begin
                        // [RQ13] Ascending word order
                        s_next.buf_w[s_reg.fill[1:0]] = fifo_word;
                        s_next.fill                   = s_reg.fill + 3'h1;
                        fifo_pop                      = 1'b1;
                    end
                end else begin
                    // [RQ1] [RQ2] [RQ4] [RQ5] [RQ6] Pick id
                    s_next.id   = out_id(s_reg.tel[1:0]);
                    s_next.len  = want;
                    s_next.both = 1'b0;
                    s_next.st   = ST_SEND;
                end
            end
            // Hold the telegram until taken
            ST_SEND: begin
                if (tx_ready_i) begin
                    s_next.left = s_reg.left - 5'(s_reg.len);
                    s_next.tel  = s_reg.tel + 3'h1;
                    s_next.fill = 3'h0;
                    // [RQ3] Stop after last telegram
                    if (s_reg.left == 5'(s_reg.len)) begin
                        // [RQ7] Sync closes the cycle
                        s_next.st   = ST_SYNC;
                        s_next.id   = SYNC_ID;
                        s_next.len  = 3'h0;
                        s_next.both = 1'b1;
                    end else begin
                        s_next.st = ST_COLLECT;
                    end
                end
            end
            // Hold the sync until taken
            ST_SYNC: begin
                if (tx_ready_i) begin
                    s_next.st   = ST_IDLE;
                    s_next.both = 1'b0;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
        // Receive: match against this drive's input ids
        if (rx_valid_i) begin
            for (int n = 0; n < MAX_TELS; n++) begin
                if (3'(n) < exp_tels && rx_id_i == in_id(2'(n))) begin
                    for (int k = 0; k < WORDS_PER_TEL; k++) begin
                        if (5'(n * WORDS_PER_TEL + k) < words) begin
                            s_next.img[n * WORDS_PER_TEL + k] = rx_data_i[k*16 +: 16];
                        end
                    end
                end
            end
        end
        // [RQ12] Fault overlays word zero
        if (slave_timeout_i && input_index_i == 4'h0) begin
            s_next.rd = FAULT_TIMEOUT;
        end else begin
            s_next.rd = s_next.img[input_index_i];
        end
    end

    // Register the whole state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            s_reg.st       <= ST_IDLE;
            s_reg.tel      <= 3'h0;
            s_reg.left     <= 5'h00;
            s_reg.fill     <= 3'h0;
            s_reg.buf_w    <= '0;
            s_reg.id       <= 11'h000;
            s_reg.len      <= 3'h0;
            s_reg.both     <= 1'b0;
            s_reg.img      <= '0;
            s_reg.rd       <= WORD_RST;
            s_reg.io_bytes <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    assign tx_valid_o    = (s_reg.st == ST_SEND) || (s_reg.st == ST_SYNC);
    assign tx_id_o       = s_reg.id;
    assign tx_data_o     = (s_reg.st == ST_SEND) ? s_reg.buf_w : 64'h0;
    assign tx_len_o      = s_reg.len;
    assign tx_both_o     = s_reg.both;
    assign input_words_o = s_reg.rd;
    assign io_bytes_o    = s_reg.io_bytes;
    assign busy_o        = (s_reg.st != ST_IDLE);

    // ==================================================================
    // Checks
    // ==================================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Data telegram on offer
    sequence s_data_tel(int n);
        s_reg.st == ST_SEND && s_reg.tel == 3'(n);
    endsequence

    // Last data telegram taken
    sequence s_last_taken;
        s_reg.st == ST_SEND && tx_ready_i && s_reg.left == 5'(s_reg.len);
    endsequence

    a_fixed_ids: assert property (s_data_tel(0) and !multi_axis_i // [RQ1]
        |-> tx_id_o == 11'(base_id + IDW'(1)) && tx_len_o == 3'h3)
        else $error("three-word drive id or length wrong");
    a_multi_first: assert property (s_data_tel(0) and multi_axis_i // [RQ2]
        |-> tx_id_o == 11'(base_id))
        else $error("multi-axis first id wrong");
    a_tel_count: assert property (s_last_taken // [RQ3]
        |=> s_reg.st == ST_SYNC && s_reg.tel == exp_tels)
        else $error("telegram count wrong");
    a_second_id: assert property (s_data_tel(1) // [RQ4]
        |-> tx_id_o == 11'(base_id + IDW'(1)))
        else $error("second telegram id wrong");
    a_third_id: assert property (s_data_tel(2) // [RQ5]
        |-> tx_id_o == 11'(base_id + IDW'(2)))
        else $error("third telegram id wrong");
    a_fourth_id: assert property (s_data_tel(3) // [RQ6]
        |-> tx_id_o == 11'(base_id + IDW'(6)))
        else $error("fourth telegram id wrong");
    a_sync_tel: assert property (s_last_taken // [RQ7]
        |=> tx_valid_o && tx_id_o == 11'h001 && tx_both_o && tx_len_o == 3'h0)
        else $error("sync telegram missing or wrong");
    a_io_bytes: assert property (rst_b_i && process_word_count_i == 7'h10 // [RQ8]
        |=> io_bytes_o == 8'h20)
        else $error("polled byte length wrong");
    a_zero_lost: assert property (s_reg.st == ST_COLLECT && !fieldbus_ok_i // [RQ11]
        && s_reg.fill < want |=> s_reg.buf_w[$past(s_reg.fill[1:0])] == 16'h0000)
        else $error("word not zeroed on fieldbus loss");
    a_fault_word: assert property (slave_timeout_i && input_index_i == 4'h0 // [RQ12]
        |=> input_words_o == 16'h006f)
        else $error("fault code missing on timeout");
    a_tel_size: assert property (tx_valid_o |-> tx_len_o <= 3'h4) // [RQ13]
        else $error("telegram longer than four words");

endmodule

`default_nettype wire

// >>> tel_sink.sv
// Behavioural telegram sink standing in for the system_bus sender and slaves.
// Assumes one clock shared with the mapper; records every telegram it takes.
`default_nettype none

module tel_sink (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // Telegram from the mapper
    input  wire logic        tx_valid_i,
    input  wire logic [10:0] tx_id_i,
    input  wire logic [63:0] tx_data_i,
    input  wire logic [2:0]  tx_len_i,
    input  wire logic        tx_both_i,
    output logic             tx_ready_o,
    // Test control
    input  wire logic        stall_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // Capture queues
    // ==================================================================
    logic [10:0] q_id [$];   // Identifiers in order taken
    logic [63:0] q_data [$]; // Packed words
    logic [2:0]  q_len [$];  // Word counts
    logic        q_both [$]; // Both-channel flags
    logic        phase;      // Alternates to throttle ready

    // Take on valid and ready; stall halves the accept rate
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            tx_ready_o <= 1'b0;
            phase      <= 1'b0;
        end else begin
            if (tx_valid_i && tx_ready_o) begin
                q_id.push_back(tx_id_i);
                q_data.push_back(tx_data_i);
                q_len.push_back(tx_len_i);
                q_both.push_back(tx_both_i);
            end
            phase      <= ~phase;
            tx_ready_o <= stall_i ? phase : 1'b1;
        end
    end

    // Forget earlier cycles before a new one
    task clear();
        q_id.delete();
        q_data.delete();
        q_len.delete();
        q_both.delete();
    endtask
endmodule

`default_nettype wire

// >>> pd_can_id_mapper_tb.sv
// Self-checking bench for the process word mapper.
// Assumes the telegram sink model takes the transmit side.
`default_nettype none

module pd_can_id_mapper_tb
    import pd_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // Signals
    // ==================================================================
    logic        clk, rst_b, multi, fb_ok, tmo, out_valid, out_ready, start, busy;
    logic        tx_valid, tx_ready, tx_both, rx_valid, stall;
    logic [7:0]  addr, io_bytes;
    logic [4:0]  dwords;
    logic [6:0]  pwc;
    logic [15:0] out_word, in_word;
    logic [3:0]  idx;
    logic [10:0] tx_id, rx_id;
    logic [63:0] tx_data, rx_data;
    logic [2:0]  tx_len;
    int          num_errors, comparisons, cycles;
    // Identifier offsets per telegram, outputs and inputs
    logic [10:0] out_ofs [4] = '{11'h000, 11'h001, 11'h002, 11'h006};
    logic [10:0] in_ofs [4]  = '{11'h003, 11'h004, 11'h005, 11'h007};

    pd_can_id_mapper pd_can_id_mapper_i (
        .ref_clk_i(clk), .rst_b_i(rst_b), .system_bus_addr_i(addr), .multi_axis_i(multi),
        .drive_words_i(dwords), .process_word_count_i(pwc), .fieldbus_ok_i(fb_ok),
        .slave_timeout_i(tmo), .output_words_i(out_word), .output_valid_i(out_valid),
        .output_ready_o(out_ready), .input_index_i(idx), .input_words_o(in_word),
        .io_bytes_o(io_bytes), .cycle_start_i(start), .busy_o(busy), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .tx_id_o(tx_id), .tx_data_o(tx_data), .tx_len_o(tx_len),
        .tx_both_o(tx_both), .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_data_i(rx_data));

    tel_sink tel_sink_i (
        .ref_clk_i(clk), .rst_b_i(rst_b), .tx_valid_i(tx_valid), .tx_id_i(tx_id),
        .tx_data_i(tx_data), .tx_len_i(tx_len), .tx_both_i(tx_both),
        .tx_ready_o(tx_ready), .stall_i(stall));

    // ==================================================================
    // Clock, watchdog and helpers
    // ==================================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    task print_verdict();
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Held until ready is seen high at an edge
    task push_words(input int n, input logic [15:0] base);
        int i, w;
        for (i = 0; i < n; i++) begin
            out_word  <= base + 16'(i);
            out_valid <= 1'b1;
            @(posedge clk);
            for (w = 0; w < 200 && out_ready !== 1'b1; w++) @(posedge clk);
        end
        out_valid <= 1'b0;
    endtask

    task run_cycle();
        int w;
        tel_sink_i.clear();
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        for (w = 0; w < 300 && busy !== 1'b0; w++) @(posedge clk);
    endtask

    // Data telegrams in order, remainder last, then the sync telegram
    task check_tels(input int n, input logic mul, input logic zero, input logic [15:0] base);
        int nt, t, k, len;
        logic [63:0] exp, msk;
        nt = mul ? (n + 3) / 4 : 1;
        chk(64'(tel_sink_i.q_id.size()), 64'(nt + 1));
        for (t = 0; t < nt && t < tel_sink_i.q_id.size(); t++) begin
            len = mul ? ((t == nt - 1) ? n - 4 * t : 4) : 3;
            exp = '0;
            msk = '0;
            for (k = 0; k < len; k++) begin
                exp[16*k +: 16] = zero ? 16'h0000 : base + 16'(4 * t + k);
                msk[16*k +: 16] = 16'hffff;
            end
            chk(64'(tel_sink_i.q_id[t]), 64'(11'(8 * addr) + (mul ? out_ofs[t] : 11'h001)));
            chk(64'(tel_sink_i.q_len[t]), 64'(len));
            chk(tel_sink_i.q_data[t] & msk, exp);
            chk(64'(tel_sink_i.q_both[t]), 64'h0);
        end
        if (tel_sink_i.q_id.size() == nt + 1) begin
            chk(64'(tel_sink_i.q_id[nt]), 64'h001);
            chk(64'({tel_sink_i.q_len[nt], tel_sink_i.q_both[nt]}), 64'h1);
        end
    endtask

    task send_rx(input logic [10:0] id, input logic [63:0] d);
        rx_id    <= id;
        rx_data  <= d;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        @(posedge clk);
    endtask

    task read_word(input logic [3:0] i, input logic [15:0] exp);
        idx <= i;
        tick(2);
        chk(64'(in_word), 64'(exp));
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    task test_io_bytes();
        static logic [6:0] cnt [5] = '{7'h00, 7'h01, 7'h10, 7'h40, 7'h64};
        static logic [7:0] exp [5] = '{8'h02, 8'h02, 8'h20, 8'h80, 8'h80};
        for (int i = 0; i < 5; i++) begin
            pwc <= cnt[i];
            tick(2);
            chk(64'(io_bytes), 64'(exp[i]));
        end
    endtask

    task test_fixed();
        multi <= 1'b0;
        push_words(3, 16'h1100);
        run_cycle();
        check_tels(3, 1'b0, 1'b0, 16'h1100);
    endtask

    task test_multi();
        static int sizes [6] = '{1, 4, 5, 8, 9, 13};
        multi <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            dwords <= 5'(sizes[i]);
            push_words(sizes[i], 16'h2200 + 16'(32 * i));
            run_cycle();
            check_tels(sizes[i], 1'b1, 1'b0, 16'h2200 + 16'(32 * i));
        end
    endtask

    // Fill the buffer until it refuses, then drain into a slow sink
    task test_fifo_full();
        dwords <= 5'h10;
        stall  <= 1'b1;
        push_words(16, 16'h3300);
        tick(1);
        chk(64'(out_ready), 64'h0);
        run_cycle();
        check_tels(16, 1'b1, 1'b0, 16'h3300);
        stall <= 1'b0;
    endtask

    task test_receive();
        for (int t = 0; t < 4; t++) begin
            send_rx(11'(8 * addr) + in_ofs[t], {4{16'h4400 + 16'(t)}});
        end
        send_rx(11'(8 * addr) + 11'h006, {4{16'hdead}});
        for (int i = 0; i < 16; i++) begin
            read_word(4'(i), 16'h4400 + 16'(i / 4));
        end
        multi <= 1'b0;
        send_rx(11'(8 * addr), {4{16'h5500}});
        read_word(4'h2, 16'h5500);
    endtask

    task test_timeout();
        tmo <= 1'b1;
        read_word(4'h0, 16'h006f);
        tmo <= 1'b0;
        read_word(4'h0, 16'h5500);
    endtask

    // Zero words without waiting for the buffer, then normal data again
    task test_loss();
        multi  <= 1'b1;
        dwords <= 5'h06;
        // High address puts the ids near the top of the 11-bit range
        addr   <= 8'hfe;
        fb_ok  <= 1'b0;
        run_cycle();
        check_tels(6, 1'b1, 1'b1, 16'h0000);
        fb_ok <= 1'b1;
        push_words(6, 16'h6600);
        run_cycle();
        check_tels(6, 1'b1, 1'b0, 16'h6600);
    endtask

    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        {rst_b, multi, tmo, out_valid, start, rx_valid, stall} = '0;
        fb_ok    = 1'b1;
        // Master polls us at our switch address
        addr     = 8'h25;
        dwords   = 5'h01;
        pwc      = 7'h10;
        out_word = 16'h0000;
        idx      = 4'h0;
        rx_id    = 11'h000;
        rx_data  = 64'h0;
        tick(6);
        rst_b <= 1'b1;
        tick(1);
        chk(64'({busy, tx_valid, out_ready}), 64'h1);
        test_io_bytes();
        test_fixed();
        test_multi();
        test_fifo_full();
        test_receive();
        test_timeout();
        test_loss();
        print_verdict();
    end
endmodule

`default_nettype wire
